// ---- tim_pkg.sv ----
// Purpose: shared constants for the two-channel capture/compare timer
// Assumes: APB, 32-bit data, one register per aligned word
// Notes: counter and values are 16 bits
package tim_pkg;
    // =========================================
    // register byte offsets
    localparam logic [7:0] ADDR_STAT_CTL = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_LIMIT = 8'h08;
    localparam logic [7:0] ADDR_CH0_CTL = 8'h0C;
    localparam logic [7:0] ADDR_CH0_HI = 8'h10;
    localparam logic [7:0] ADDR_CH0_LO = 8'h14;
    localparam logic [7:0] ADDR_CH1_CTL = 8'h18;
    localparam logic [7:0] ADDR_CH1_HI = 8'h1C;
    localparam logic [7:0] ADDR_CH1_LO = 8'h20;
    // =========================================
    // status/control field positions
    localparam int SC_WRAP_FLAG = 7;
    localparam int SC_WRAP_IE = 6;
    localparam int SC_STOP = 5;
    localparam int SC_RESET = 4;
    // channel control field positions
    localparam int CH_FLAG = 7;
    localparam int CH_IE = 6;
    localparam int CH_MSB = 5;
    localparam int CH_MSA = 4;
    localparam int CH_ELSB = 3;
    localparam int CH_ELSA = 2;
    localparam int CH_TOV = 1;
    localparam int CH_MAX = 0;
    // =========================================
    // reset values
    localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
    localparam logic [7:0] SC_RESET_VAL = 8'h20;
    localparam logic [2:0] DIV_SEL_MAX = 3'h6;
endpackage : tim_pkg

// ---- chan_if.sv ----
// Purpose: carries one channel's control and events between modules
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
    logic [7:0] ctl;
    logic [15:0] value;
    logic [15:0] count;
    logic tick;
    logic wrap;
    logic pin_in;
    logic event_hit;
    logic capture;
    logic pin_out;
    logic pin_oe;
    modport top (output ctl, value, count, tick, wrap, pin_in,
                 input event_hit, capture, pin_out, pin_oe);
    modport chan (input ctl, value, count, tick, wrap, pin_in,
                  output event_hit, capture, pin_out, pin_oe);
endinterface : chan_if
`default_nettype wire

// ---- tim_chan.sv ----
// Purpose: one capture/compare/pwm channel
// Assumes: pin_in already synchronised
// Notes: capture strobe tells top to latch count
`timescale 1ns/1ps
`default_nettype none
module tim_chan
    import tim_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // channel link
    chan_if.chan ch
);
    logic pin_d_r, pin_d_nxt;
    logic out_r, out_nxt;
    logic is_out, rise, fall, edge_hit, match;

    // =========================================
    // edge detect and compare
    always_comb begin
        is_out = ch.ctl[CH_MSB] | ch.ctl[CH_MSA];
        rise = ch.pin_in & ~pin_d_r;
        fall = ~ch.pin_in & pin_d_r;
        edge_hit = (ch.ctl[CH_ELSA] & rise) | (ch.ctl[CH_ELSB] & fall); // R03
        match = ch.tick & (ch.count == ch.value);
        pin_d_nxt = ch.pin_in;
        out_nxt = out_r;
        if (is_out) begin
            if (ch.wrap & ch.ctl[CH_TOV]) begin
                out_nxt = ~out_r; // R14
            end
            if (match) begin
                case (ch.ctl[CH_ELSB:CH_ELSA]) // R05
                    2'b01: out_nxt = ~out_r;
                    2'b10: out_nxt = 1'b0; // R22
                    2'b11: out_nxt = 1'b1; // R22
                    default: out_nxt = out_r;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_d_r <= 1'b0;
            out_r <= 1'b0;
        end else begin
            pin_d_r <= pin_d_nxt;
            out_r <= out_nxt;
        end
    end

    // =========================================
    // outputs
    assign ch.capture = ~is_out & edge_hit; // R02
    assign ch.event_hit = is_out ? match : edge_hit; // R04 R06
    // full duty forces high while toggling on wrap
    assign ch.pin_out = (ch.ctl[CH_MAX] & ch.ctl[CH_TOV]) ? 1'b1 : out_r; // R24 R23
    assign ch.pin_oe = is_out & (ch.ctl[CH_ELSB] | ch.ctl[CH_ELSA]);
endmodule : tim_chan
`default_nettype wire

// ---- timer_capture_compare_pwm.sv ----
// Purpose: two-channel 16-bit timer with capture, compare and pwm
// Assumes: APB slave, zero wait states, channel pins asynchronous
// Notes: interrupt requests are plain level outputs
//
// What this block does
// R01 - eight prescaled rates picked by select field
// R02 - capture copies counter on active edge
// R03 - software picks capture edge polarity
// R04 - capture can request interrupt when enabled
// R05 - compare match sets, clears or toggles pin
// R06 - compare match can request interrupt when enabled
// R07 - unbuffered write replaces compare value at once
// R08 - software lowers value from compare handler
// R09 - software raises value from wrap handler
// R10 - link bit pairs channels onto pin 0
// R11 - last written pair becomes active at wrap
// R12 - linked: channel 0 control governs, pin 1 free
// R13 - software writes only the inactive pair
// R14 - toggle on wrap sets pwm period
// R15 - software picks clear or set for polarity
// R16 - limit 255 undivided gives 256 clocks
// R17 - value 128 of 256 gives half duty
// R18 - software shortens pulse from compare handler
// R19 - software lengthens pulse from wrap handler
// R20 - software avoids toggle action for pwm
// R21 - wrap flag sets when counter ticks from limit back to zero
// R22 - edge/level 10 clears, 11 sets
// R23 - no toggle on wrap gives zero duty
// R24 - full duty plus toggle gives constant high
// R25 - counter counts ticks, wraps after limit
// R26 - value commits after high then low byte
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_pwm
    import tim_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // channel pins
    input wire logic CHAN0_PIN_I,
    output logic CHAN0_PIN_O,
    output logic CHAN0_PIN_OE,
    input wire logic CHAN1_PIN_I,
    output logic CHAN1_PIN_O,
    output logic CHAN1_PIN_OE,
    // interrupt requests
    output logic WRAP_IRQ,
    output logic CHAN0_IRQ,
    output logic CHAN1_IRQ
);
    chan_if c0();
    chan_if c1();

    logic [7:0] sc_r, sc_nxt;
    logic [6:0] pre_r, pre_nxt;
    logic [15:0] count_r, count_nxt;
    logic [15:0] limit_r, limit_nxt;
    logic [7:0] ctl0_r, ctl0_nxt, ctl1_r, ctl1_nxt;
    logic [15:0] val0_r, val0_nxt, val1_r, val1_nxt;
    logic [7:0] hi0_r, hi0_nxt, hi1_r, hi1_nxt;
    logic [7:0] lim_hi_r, lim_hi_nxt;
    logic act1_r, act1_nxt, last1_r, last1_nxt;
    logic sc_seen_r, sc_seen_nxt, f0_seen_r, f0_seen_nxt, f1_seen_r, f1_seen_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] s0_r, s0_nxt, s1_r, s1_nxt;
    logic tick, wrap, wr, rd, linked, at_limit;
    logic [7:0] wb;

    // =========================================
    // pin synchronisers
    always_comb begin
        s0_nxt = {s0_r[0], CHAN0_PIN_I};
        s1_nxt = {s1_r[0], CHAN1_PIN_I};
    end

    // =========================================
    // prescaler and counter
    always_comb begin
        pre_nxt = pre_r + 7'h01;
        case (sc_r[2:0]) // R01
            3'h0: tick = 1'b1;
            3'h1: tick = pre_r[0];
            3'h2: tick = &pre_r[1:0];
            3'h3: tick = &pre_r[2:0];
            3'h4: tick = &pre_r[3:0];
            3'h5: tick = &pre_r[4:0];
            3'h6: tick = &pre_r[5:0];
            default: tick = &pre_r[6:0];
        endcase
        if (sc_r[SC_STOP]) begin
            tick = 1'b0;
            pre_nxt = pre_r;
        end
        at_limit = (count_r == limit_r);
        wrap = tick & at_limit; // R25
        count_nxt = count_r;
        if (tick) begin
            count_nxt = at_limit ? 16'h0000 : count_r + 16'h0001; // R25 R16
        end
        // software counter reset clears prescaler too
        if (wr && PADDR == ADDR_STAT_CTL && wb[SC_RESET]) begin
            pre_nxt = 7'h00;
            count_nxt = 16'h0000;
        end
    end

    // =========================================
    // apb access
    assign PREADY = 1'b1;
    assign wr = PSEL & PENABLE & PWRITE;
    assign rd = PSEL & PENABLE & ~PWRITE;
    assign wb = PWDATA[7:0];
    assign linked = ctl0_r[CH_MSB]; // R10

    always_comb begin
        sc_nxt = sc_r;
        limit_nxt = limit_r;
        lim_hi_nxt = lim_hi_r;
        ctl0_nxt = ctl0_r;
        ctl1_nxt = ctl1_r;
        val0_nxt = val0_r;
        val1_nxt = val1_r;
        hi0_nxt = hi0_r;
        hi1_nxt = hi1_r;
        act1_nxt = act1_r;
        last1_nxt = last1_r;
        sc_seen_nxt = sc_seen_r;
        f0_seen_nxt = f0_seen_r;
        f1_seen_nxt = f1_seen_r;
        rdata_nxt = 32'h0000_0000;
        PSLVERR = 1'b0;
        if (rd) begin
            if (PADDR == ADDR_STAT_CTL) begin
                sc_seen_nxt = sc_r[SC_WRAP_FLAG];
            end else if (PADDR == ADDR_CH0_CTL) begin
                f0_seen_nxt = ctl0_r[CH_FLAG];
            end else if (PADDR == ADDR_CH1_CTL) begin
                f1_seen_nxt = ctl1_r[CH_FLAG];
            end
        end
        if (wr) begin
            if (PADDR == ADDR_STAT_CTL) begin
                sc_nxt = {sc_r[7], wb[6:5], 2'b00, wb[2:0]};
                if (!wb[7] && sc_seen_r) begin
                    sc_nxt[SC_WRAP_FLAG] = 1'b0;
                end
                sc_seen_nxt = 1'b0;
            end else if (PADDR == ADDR_LIMIT) begin
                limit_nxt = PWDATA[15:0];
            end else if (PADDR == ADDR_CH0_CTL) begin
                ctl0_nxt = {ctl0_r[7], wb[6:0]};
                if (!wb[7] && f0_seen_r) begin
                    ctl0_nxt[CH_FLAG] = 1'b0;
                end
                f0_seen_nxt = 1'b0;
            end else if (PADDR == ADDR_CH0_HI) begin
                hi0_nxt = wb;
            end else if (PADDR == ADDR_CH0_LO) begin
                val0_nxt = {hi0_r, wb}; // R26 R07
                last1_nxt = 1'b0;
            end else if (PADDR == ADDR_CH1_CTL) begin
                ctl1_nxt = {ctl1_r[7], wb[6:4] & 3'b101, wb[3:0]};
                if (!wb[7] && f1_seen_r) begin
                    ctl1_nxt[CH_FLAG] = 1'b0;
                end
                f1_seen_nxt = 1'b0;
            end else if (PADDR == ADDR_CH1_HI) begin
                hi1_nxt = wb;
            end else if (PADDR == ADDR_CH1_LO) begin
                val1_nxt = {hi1_r, wb}; // R26
                last1_nxt = 1'b1;
            end else if (PADDR != ADDR_COUNT) begin
                PSLVERR = 1'b1;
            end
        end
        if (rd) begin
            if (PADDR == ADDR_STAT_CTL) begin
                rdata_nxt = {24'h00_0000, sc_r};
            end else if (PADDR == ADDR_COUNT) begin
                rdata_nxt = {16'h0000, count_r};
            end else if (PADDR == ADDR_LIMIT) begin
                rdata_nxt = {16'h0000, limit_r};
            end else if (PADDR == ADDR_CH0_CTL) begin
                rdata_nxt = {24'h00_0000, ctl0_r};
            end else if (PADDR == ADDR_CH0_HI) begin
                rdata_nxt = {24'h00_0000, val0_r[15:8]};
            end else if (PADDR == ADDR_CH0_LO) begin
                rdata_nxt = {24'h00_0000, val0_r[7:0]};
            end else if (PADDR == ADDR_CH1_CTL) begin
                rdata_nxt = {24'h00_0000, ctl1_r};
            end else if (PADDR == ADDR_CH1_HI) begin
                rdata_nxt = {24'h00_0000, val1_r[15:8]};
            end else if (PADDR == ADDR_CH1_LO) begin
                rdata_nxt = {24'h00_0000, val1_r[7:0]};
            end else begin
                PSLVERR = 1'b1;
            end
        end
        // linked source switches only at wrap
        if (!linked) begin
            act1_nxt = 1'b0;
        end else if (wrap) begin
            act1_nxt = last1_nxt; // R11
        end
        // hardware sets win over software clears
        if (wrap) begin
            sc_nxt[SC_WRAP_FLAG] = 1'b1; // R21
        end
        if (c0.event_hit) begin
            ctl0_nxt[CH_FLAG] = 1'b1; // R04 R06
        end
        if (c1.event_hit && !linked) begin
            ctl1_nxt[CH_FLAG] = 1'b1; // R12
        end
        if (c0.capture) begin
            val0_nxt = count_r; // R02
        end
        if (c1.capture && !linked) begin
            val1_nxt = count_r; // R02
        end
        lim_hi_nxt = lim_hi_r;
    end

    // =========================================
    // channel wiring
    assign c0.ctl = ctl0_r;
    assign c0.value = (linked && act1_r) ? val1_r : val0_r; // R11
    // compare on the value being reached, so width equals value
    assign c0.count = count_nxt; // R17
    assign c0.tick = tick;
    assign c0.wrap = wrap;
    assign c0.pin_in = s0_r[1];
    assign c1.ctl = linked ? 8'h00 : ctl1_r; // R12
    assign c1.value = val1_r;
    assign c1.count = count_nxt;
    assign c1.tick = tick;
    assign c1.wrap = wrap;
    assign c1.pin_in = s1_r[1];

    tim_chan u_chan0 (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .ch(c0)
    );

    tim_chan u_chan1 (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .ch(c1)
    );

    assign CHAN0_PIN_O = c0.pin_out;
    assign CHAN0_PIN_OE = c0.pin_oe;
    assign CHAN1_PIN_O = c1.pin_out;
    assign CHAN1_PIN_OE = c1.pin_oe; // R12
    assign PRDATA = rdata_r;
    assign WRAP_IRQ = sc_r[SC_WRAP_FLAG] & sc_r[SC_WRAP_IE];
    assign CHAN0_IRQ = ctl0_r[CH_FLAG] & ctl0_r[CH_IE]; // R04 R06
    assign CHAN1_IRQ = ctl1_r[CH_FLAG] & ctl1_r[CH_IE] & ~linked;

    // =========================================
    // state registers
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            s0_r <= 2'b00;
            s1_r <= 2'b00;
            sc_r <= SC_RESET_VAL;
            pre_r <= 7'h00;
            count_r <= 16'h0000;
            limit_r <= LIMIT_RESET;
            lim_hi_r <= 8'h00;
            ctl0_r <= 8'h00;
            ctl1_r <= 8'h00;
            val0_r <= 16'h0000;
            val1_r <= 16'h0000;
            hi0_r <= 8'h00;
            hi1_r <= 8'h00;
            act1_r <= 1'b0;
            last1_r <= 1'b0;
            sc_seen_r <= 1'b0;
            f0_seen_r <= 1'b0;
            f1_seen_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            s0_r <= s0_nxt;
            s1_r <= s1_nxt;
            sc_r <= sc_nxt;
            limit_r <= limit_nxt;
            lim_hi_r <= lim_hi_nxt;
            ctl0_r <= ctl0_nxt;
            ctl1_r <= ctl1_nxt;
            val0_r <= val0_nxt;
            val1_r <= val1_nxt;
            hi0_r <= hi0_nxt;
            hi1_r <= hi1_nxt;
            act1_r <= act1_nxt;
            last1_r <= last1_nxt;
            sc_seen_r <= sc_seen_nxt;
            f0_seen_r <= f0_seen_nxt;
            f1_seen_r <= f1_seen_nxt;
            rdata_r <= rdata_nxt;
            pre_r <= pre_nxt;
            count_r <= count_nxt;
        end
    end
endmodule : timer_capture_compare_pwm
`default_nettype wire

// ---- tim_properties.sv ----
// Purpose: port-level checks for the capture/compare timer
// Assumes: zero-wait apb, control written whole
// Notes: shadows channel 0 and status control writes
`timescale 1ns/1ps
`default_nettype none
module tim_properties
    import tim_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // pins and requests
    input wire logic CHAN0_PIN_O,
    input wire logic CHAN0_PIN_OE,
    input wire logic CHAN1_PIN_OE,
    input wire logic WRAP_IRQ,
    input wire logic CHAN0_IRQ,
    input wire logic CHAN1_IRQ
);
    // ==========================================
    // shadow of software writes
    logic wr;
    logic cmp;
    logic [7:0] c0_r, c0_nxt, sc_r, sc_nxt;
    assign wr = PSEL && PENABLE && PWRITE && PREADY;
    assign cmp = c0_r[CH_MSB] || c0_r[CH_MSA];
    always_comb begin
        c0_nxt = (wr && PADDR == ADDR_CH0_CTL) ? PWDATA[7:0] : c0_r;
        sc_nxt = (wr && PADDR == ADDR_STAT_CTL) ? PWDATA[7:0] : sc_r;
    end
    always_ff @(posedge SYS_CLK) begin
        c0_r <= RST_N ? c0_nxt : 8'h00;
        sc_r <= RST_N ? sc_nxt : SC_RESET_VAL;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    a_ready_high: assert property (PREADY) else $error("ready low");
    a_unmapped_err: assert property (PSEL && PENABLE && PADDR > ADDR_CH1_LO |-> PSLVERR)
        else $error("no error on unmapped access");
    a_read_clear: assert property (!(PSEL && PENABLE && !PWRITE) |=> PRDATA == 32'h0000_0000)
        else $error("read data not cleared");
    a_link_pin_free: assert property (c0_r[CH_MSB] |-> !CHAN1_PIN_OE)
        else $error("pin 1 driven while linked");
    a_link_irq_mask: assert property (c0_r[CH_MSB] |-> !CHAN1_IRQ)
        else $error("channel 1 request while linked");
    a_full_duty: assert property (cmp && c0_r[CH_TOV] && c0_r[CH_MAX] |-> CHAN0_PIN_O)
        else $error("full duty not high");
    a_chan_irq_off: assert property (!c0_r[CH_IE] |-> !CHAN0_IRQ)
        else $error("channel request while disabled");
    a_wrap_irq_off: assert property (!sc_r[SC_WRAP_IE] |-> !WRAP_IRQ)
        else $error("wrap request while disabled");
    a_wrap_clr_write: assert property ($fell(WRAP_IRQ) |-> $past(wr))
        else $error("wrap request dropped without write");
    a_capture_input: assert property (!cmp |-> !CHAN0_PIN_OE)
        else $error("capture pin driven");
endmodule : tim_properties
bind timer_capture_compare_pwm tim_properties tim_properties_inst (.SYS_CLK, .RST_N,
    .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CHAN0_PIN_O,
    .CHAN0_PIN_OE, .CHAN1_PIN_OE, .WRAP_IRQ, .CHAN0_IRQ, .CHAN1_IRQ);
`default_nettype wire

// ---- pin_model.sv ----
// Purpose: external sources and loads on the two channel pins
// Assumes: pin driven by device when enable high
// Notes: otherwise the external level shows
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    // external levels
    input wire logic ext0,
    input wire logic ext1,
    // device side
    input wire logic o0,
    input wire logic oe0,
    input wire logic o1,
    input wire logic oe1,
    output logic pin0,
    output logic pin1
);
    // ==========================================
    // wire resolution
    assign pin0 = oe0 ? o0 : ext0;
    assign pin1 = oe1 ? o1 : ext1;
endmodule : pin_model
`default_nettype wire

// ---- timer_capture_compare_pwm_test.sv ----
// Purpose: self-checking bench for the capture/compare timer
// Assumes: zero-wait apb, read data one cycle after access
// Notes: pin levels resolved in pin_model
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_pwm_test
    import tim_pkg::*;
;
    // ==========================================
    // signals
    logic SYS_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA, q;
    logic PREADY, PSLVERR, last_err, ext0 = 0, ext1 = 0, CHAN0_PIN_I, CHAN1_PIN_I;
    logic CHAN0_PIN_O, CHAN0_PIN_OE, CHAN1_PIN_O, CHAN1_PIN_OE, WRAP_IRQ, CHAN0_IRQ, CHAN1_IRQ;
    int mismatches = 0, check_count = 0;
    timer_capture_compare_pwm timer_capture_compare_pwm_inst (.SYS_CLK, .RST_N, .PSEL,
        .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CHAN0_PIN_I,
        .CHAN0_PIN_O, .CHAN0_PIN_OE, .CHAN1_PIN_I, .CHAN1_PIN_O, .CHAN1_PIN_OE,
        .WRAP_IRQ, .CHAN0_IRQ, .CHAN1_IRQ);
    pin_model pin_model_inst (.ext0, .ext1, .o0(CHAN0_PIN_O), .oe0(CHAN0_PIN_OE),
        .o1(CHAN1_PIN_O), .oe1(CHAN1_PIN_OE), .pin0(CHAN0_PIN_I), .pin1(CHAN1_PIN_I));
    initial forever #12.5 SYS_CLK = ~SYS_CLK;
    // ==========================================
    // shared tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        @(posedge SYS_CLK);
        while (PREADY !== 1'b1) @(posedge SYS_CLK);
        last_err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // registered read data stands in the cycle after the access
        @(posedge SYS_CLK);
        q = PRDATA;
    endtask : apb
    task automatic wait_lvl(input logic v, output int n);
        n = 0;
        do begin
            @(posedge SYS_CLK);
            #1 n++;
        end while (CHAN0_PIN_O !== v && n < 20000);
    endtask : wait_lvl
    task automatic measure(output int hi, output int per);
        int n;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, hi);
        wait_lvl(1'b1, per);
        per += hi;
    endtask : measure
    task automatic start_pwm(input logic [2:0] sel, input logic [15:0] v, input logic [7:0] c);
        apb(1, ADDR_STAT_CTL, 32'h0000_0030);
        apb(1, ADDR_LIMIT, 32'h0000_00FF);
        apb(1, ADDR_CH0_HI, {24'h00_0000, v[15:8]});
        apb(1, ADDR_CH0_LO, {24'h00_0000, v[7:0]});
        apb(1, ADDR_CH0_CTL, {24'h00_0000, c});
        apb(1, ADDR_STAT_CTL, {29'h0000_0000, sel});
    endtask : start_pwm
    // ==========================================
    // scenarios
    task automatic t_reset();
        apb(0, ADDR_STAT_CTL, 0);
        check("status reset", q, 32'h0000_0020);
        apb(0, ADDR_LIMIT, 0);
        check("limit reset", q, 32'h0000_FFFF);
        apb(0, ADDR_COUNT, 0);
        check("halted count", q, 32'h0000_0000);
        apb(0, 8'h40, 0);
        check("unmapped error", last_err, 1);
    endtask : t_reset
    task automatic t_capture();
        logic [31:0] c0, h;
        apb(1, ADDR_LIMIT, 32'h0000_FFFF);
        apb(1, ADDR_CH0_CTL, 32'h0000_0044);
        apb(1, ADDR_CH1_CTL, 32'h0000_0048);
        apb(1, ADDR_STAT_CTL, 32'h0000_0010);
        apb(0, ADDR_COUNT, 0);
        c0 = q;
        ext0 <= 1'b1;
        ext1 <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        #1 check("rising ignored", CHAN1_IRQ, 0);
        check("capture request", CHAN0_IRQ, 1);
        apb(0, ADDR_CH0_HI, 0);
        h = q;
        apb(0, ADDR_CH0_LO, 0);
        h = {h[7:0], q[7:0]};
        apb(0, ADDR_COUNT, 0);
        check("capture value", h > c0 && h < q, 1);
        ext1 <= 1'b0;
        repeat (6) @(posedge SYS_CLK);
        #1 check("falling capture", CHAN1_IRQ, 1);
    endtask : t_capture
    task automatic t_pwm();
        int hi, per;
        logic [7:0] ctl [3] = '{8'h1A, 8'h1E, 8'h1A};
        logic [15:0] val [3] = '{16'h0040, 16'h0040, 16'h0080};
        int exp [3] = '{64, 192, 128};
        for (int i = 0; i < 3; i++) begin
            start_pwm(0, val[i], ctl[i]);
            measure(hi, per);
            check("pulse high", hi, exp[i]);
            check("period", per, 256);
        end
        apb(0, ADDR_STAT_CTL, 0);
        check("wrap flag", q[SC_WRAP_FLAG], 1);
        for (int s = 1; s < 5; s++) begin
            start_pwm(s[2:0], 16'h0080, 8'h1A);
            measure(hi, per);
            check("divided period", per, 256 << s);
        end
        start_pwm(0, 16'h0080, 8'h18);
        wait_lvl(1'b0, hi);
        wait_lvl(1'b1, hi);
        check("no toggle flat", hi, 20000);
        start_pwm(0, 16'h0080, 8'h1B);
        wait_lvl(1'b0, hi);
        check("full duty flat", hi, 20000);
    endtask : t_pwm
    task automatic t_link();
        int hi, per;
        start_pwm(0, 16'h0040, 8'h2A);
        measure(hi, per);
        check("linked ch0 width", hi, 64);
        apb(1, ADDR_CH1_HI, 32'h0000_0000);
        apb(1, ADDR_CH1_LO, 32'h0000_00C0);
        apb(1, ADDR_CH1_CTL, 32'h0000_005E);
        measure(hi, per);
        measure(hi, per);
        check("linked ch1 width", hi, 192);
        check("pin 1 released", CHAN1_PIN_OE, 0);
        apb(1, ADDR_CH0_HI, 32'h0000_0000);
        apb(1, ADDR_CH0_LO, 32'h0000_0020);
        measure(hi, per);
        measure(hi, per);
        check("back to ch0", hi, 32);
    endtask : t_link
    // ==========================================
    // run control
    task automatic print_verdict();
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #2250000;
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        t_reset();
        t_capture();
        t_pwm();
        t_link();
        print_verdict();
    end
endmodule : timer_capture_compare_pwm_test
`default_nettype wire
